// file: testbench/irm_mapper_sva.sv
/*
  irm_mapper_sva: port-level checks for the internal resource mapper.
  assumes one bus clock domain and the irm_pkg carrier types.
*/
`timescale 1ns/1ps
`default_nettype none
module irm_mapper_sva
  import irm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire irm_pkg::irm_acc_t i_acc,
  input wire logic i_extra_window_enable,
  input wire logic i_low_cs_enabled,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire irm_pkg::irm_sel_t o_sel,
  input wire irm_pkg::irm_vis_t o_vis,
  input wire logic o_port_d_mapped,
  input wire logic o_port_e_mapped,
  input wire logic o_extra_page_window_hit,
  input wire logic o_cs_narrow,
  input wire logic [2:0] o_mode,
  input wire logic o_mode_ready
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // map outputs may lag the mode by a cycle, so wait one past ready
  logic settled_r;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      settled_r <= 1'b0;
    end else begin
      settled_r <= o_mode_ready;
    end
  end
  sel_onehot_a: assert property (i_acc.valid |=> $onehot(o_sel))
    else $error("select not one-hot after a valid access");
  idle_sel_a: assert property (!i_acc.valid |=> o_sel == '0)
    else $error("select raised without a valid access");
  bdm_first_a: assert property (i_acc.valid && i_acc.bdm_active &&
    i_acc.addr[15:8] == IRM_BDM_PAGE |=> o_sel.bdm_rom)
    else $error("debug rom lost an active access");
  sc_no_vis_a: assert property (settled_r && o_mode[1:0] == 2'h0
    |-> !o_vis.drive) else $error("visibility in single-chip mode");
  ext_hidden_a: assert property (o_sel.external |-> !o_vis.drive)
    else $error("external access marked as visible internal");
  wide_vis_a: assert property (o_vis.wide |-> o_vis.drive &&
    o_mode == IRM_M_SP_NAR && !o_port_d_mapped)
    else $error("wide visibility outside special narrow emulation");
  read_idle_a: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
    else $error("read data present without a read");
  wide_no_pd_a: assert property (settled_r && o_mode[1]
    |-> !o_port_d_mapped) else $error("port d mapped in wide mode");
  sc_ports_a: assert property (settled_r && o_mode[1:0] == 2'h0
    |-> o_port_d_mapped && o_port_e_mapped)
    else $error("port registers unmapped in single-chip mode");
  mode_hold_a: assert property (o_mode_ready
    |=> o_mode_ready && $stable(o_mode)) else $error("mode changed");
  extra_page_window_ext_a: assert property (o_extra_page_window_hit |->
    o_sel.external && o_mode[0] && $past(i_extra_window_enable))
    else $error("extra window hit without cause");
  narrow_cs_a: assert property (o_cs_narrow |-> o_sel.external &&
    $past(i_low_cs_enabled)) else $error("narrow space without chip select");
  cover property (o_sel.bdm_rom);
  cover property (o_vis.wide);
  cover property (o_extra_page_window_hit);
  cover property (o_cs_narrow);
endmodule : irm_mapper_sva
bind irm_mapper irm_mapper_sva u_sva (.i_clk_sys(i_clk_sys),
  .i_resetn(i_resetn), .i_acc(i_acc),
  .i_extra_window_enable(i_extra_window_enable),
  .i_low_cs_enabled(i_low_cs_enabled), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_sel(o_sel), .o_vis(o_vis),
  .o_port_d_mapped(o_port_d_mapped), .o_port_e_mapped(o_port_e_mapped),
  .o_extra_page_window_hit(o_extra_page_window_hit), .o_cs_narrow(o_cs_narrow), .o_mode(o_mode),
  .o_mode_ready(o_mode_ready));
`default_nettype wire

// file: testbench/irm_mapper_tb_top.sv
/*
  irm_mapper_tb_top: directed register and decode bench for the mapper.
  assumes the one-cycle register port and next-cycle decode outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module irm_mapper_tb_top;
  import irm_pkg::*;
  localparam logic [7:0] S_BDM = 8'h10;
  localparam logic [7:0] S_REG = 8'h08;
  localparam logic [7:0] S_RAM = 8'h04;
  localparam logic [7:0] S_EE = 8'h02;
  localparam logic [7:0] S_EXT = 8'h01;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] strap = 3'h0;
  irm_acc_t acc = '0;
  logic extra_window_enable = 1'b0;
  logic lcs = 1'b0;
  logic [7:0] ra = 8'h00;
  logic [7:0] rwd = 8'h00;
  logic rw = 1'b0;
  logic rr = 1'b0;
  logic [7:0] rdata;
  irm_sel_t sel;
  irm_vis_t vis;
  logic pd, pe, eph, csn, rdy;
  logic [2:0] mode;
  int fails = 0;
  int compares = 0;
  logic [16:0] ta [9];
  logic [7:0] te [9];
  always #50 clk = ~clk;
  irm_mapper uut (.i_clk_sys(clk), .i_resetn(rstn), .i_bkgd_pin(strap[2]),
    .i_modb_pin(strap[1]), .i_moda_pin(strap[0]), .i_acc(acc),
    .i_extra_window_enable(extra_window_enable), .i_low_cs_enabled(lcs), .i_reg_addr(ra),
    .i_reg_wdata(rwd), .i_reg_wr(rw), .i_reg_rd(rr), .o_reg_rdata(rdata),
    .o_sel(sel), .o_vis(vis), .o_port_d_mapped(pd), .o_port_e_mapped(pe),
    .o_extra_page_window_hit(eph), .o_cs_narrow(csn), .o_mode(mode), .o_mode_ready(rdy));
  task automatic summarize();
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // straps only change under reset; the map is rebuilt from them
  task automatic rst(input logic [2:0] s);
    int n;
    n = 0;
    @(posedge clk);
    rstn <= 1'b0;
    strap <= s;
    acc <= '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    while (rdy !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      fails++;
      summarize();
    end
    @(posedge clk);
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rw <= 1'b1;
    @(posedge clk);
    rw <= 1'b0;
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [7:0] e);
    @(posedge clk);
    ra <= a;
    rr <= 1'b1;
    @(posedge clk);
    rr <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask : rdc
  task automatic dec(input logic [15:0] a, input logic b);
    @(posedge clk);
    acc <= {1'b1, 1'b0, b, a};
    @(posedge clk);
    #1;
  endtask : dec
  initial begin
    ta = '{17'h00010, 17'h001ff, 17'h00200, 17'h00c10, 17'h00bff,
           17'h01010, 17'h04000, 17'h1ff10, 17'h0ff10};
    te = '{S_REG, S_REG, S_EXT, S_RAM, S_EXT, S_EE, S_EXT, S_BDM, S_EXT};
    rst(3'h7);
    chk("mode", 8'h07, {5'h0, mode});
    rdc("modereg", IRM_OFS_MODE, 8'he0);
    rdc("rampos", IRM_OFS_RAM_POS, 8'h08);
    rdc("regpos", IRM_OFS_REG_POS, 8'h00);
    rdc("eepos", IRM_OFS_EE_POS, 8'h11);
    rdc("misc", IRM_OFS_MISC, 8'h00);
    rdc("unmapped", 8'h40, 8'h00);
    chk("pd", 8'h00, {7'h0, pd});
    chk("pe", 8'h01, {7'h0, pe});
    for (int i = 0; i < 9; i++) begin
      dec(ta[i][15:0], ta[i][16]);
      chk("sel", te[i], {3'h0, sel});
    end
    dec(16'h0010, 1'b0);
    chk("vis", 8'h00, {6'h0, vis});
    wr(IRM_OFS_MODE, 8'h08);
    wr(IRM_OFS_MODE, 8'h00);
    rdc("modereg", IRM_OFS_MODE, 8'he8);
    dec(16'h0010, 1'b0);
    chk("vis", 8'h02, {6'h0, vis});
    dec(16'h4000, 1'b0);
    chk("vis", 8'h00, {6'h0, vis});
    // access rides along with the write: old map at N, new map at N+1
    @(posedge clk);
    ra <= IRM_OFS_REG_POS;
    rwd <= 8'h10;
    rw <= 1'b1;
    acc <= {3'b100, 16'h1010};
    @(posedge clk);
    rw <= 1'b0;
    #1 chk("sel", S_EE, {3'h0, sel});
    @(posedge clk);
    #1 chk("sel", S_REG, {3'h0, sel});
    wr(IRM_OFS_REG_POS, 8'h00);
    rdc("regpos", IRM_OFS_REG_POS, 8'h10);
    dec(16'h1210, 1'b0);
    chk("sel", S_EE, {3'h0, sel});
    wr(IRM_OFS_RAM_POS, 8'h17);
    wr(IRM_OFS_RAM_POS, 8'h00);
    rdc("rampos", IRM_OFS_RAM_POS, 8'h10);
    dec(16'h1410, 1'b0);
    chk("sel", S_RAM, {3'h0, sel});
    wr(IRM_OFS_EE_POS, 8'h30);
    dec(16'h3010, 1'b0);
    chk("sel", S_EXT, {3'h0, sel});
    wr(IRM_OFS_EE_POS, 8'h01);
    rdc("eepos", IRM_OFS_EE_POS, 8'h31);
    dec(16'h3010, 1'b0);
    chk("sel", S_EE, {3'h0, sel});
    // the eeprom sits at 0x3000 here, clear of the chip-select space at 0x1200; unmap it first
    wr(IRM_OFS_EE_POS, 8'h00);
    @(posedge clk) lcs <= 1'b1;
    wr(IRM_OFS_MISC, 8'h40);
    wr(IRM_OFS_MISC, 8'h00);
    rdc("misc", IRM_OFS_MISC, 8'h40);
    dec(16'h1210, 1'b0);
    chk("narrow", 8'h01, {7'h0, csn});
    @(posedge clk) lcs <= 1'b0;
    dec(16'h1210, 1'b0);
    chk("narrow", 8'h00, {7'h0, csn});
    @(posedge clk) extra_window_enable <= 1'b1;
    dec(16'h0410, 1'b0);
    chk("extra_page_window", 8'h01, {7'h0, eph});
    @(posedge clk) extra_window_enable <= 1'b0;
    dec(16'h0410, 1'b0);
    chk("extra_page_window", 8'h00, {7'h0, eph});
    rst(3'h1);
    rdc("modereg", IRM_OFS_MODE, 8'h2b);
    chk("pd", 8'h00, {7'h0, pd});
    chk("pe", 8'h00, {7'h0, pe});
    dec(16'h0010, 1'b0);
    chk("vis", 8'h03, {6'h0, vis});
    wr(IRM_OFS_MODE, 8'h00);
    rdc("modereg", IRM_OFS_MODE, 8'h2b);
    wr(IRM_OFS_MODE, 8'h00);
    rdc("modereg", IRM_OFS_MODE, 8'h20);
    dec(16'h0010, 1'b0);
    chk("vis", 8'h00, {6'h0, vis});
    chk("pd", 8'h01, {7'h0, pd});
    chk("pe", 8'h01, {7'h0, pe});
    wr(IRM_OFS_MISC, 8'hff);
    rdc("misc", IRM_OFS_MISC, 8'hc0);
    wr(IRM_OFS_MISC, 8'h80);
    extra_window_enable <= 1'b1;
    dec(16'h0210, 1'b0);
    chk("extra_page_window", 8'h01, {7'h0, eph});
    dec(16'h0410, 1'b0);
    chk("extra_page_window", 8'h00, {7'h0, eph});
    rst(3'h0);
    rdc("modereg", IRM_OFS_MODE, 8'h0b);
    rdc("eepos", IRM_OFS_EE_POS, 8'hf1);
    wr(IRM_OFS_EE_POS, 8'hf0);
    rdc("eepos", IRM_OFS_EE_POS, 8'hf1);
    dec(16'hf010, 1'b0);
    chk("sel", S_EE, {3'h0, sel});
    chk("vis", 8'h00, {6'h0, vis});
    dec(16'h0410, 1'b0);
    chk("extra_page_window", 8'h00, {7'h0, eph});
    chk("pd", 8'h01, {7'h0, pd});
    chk("pe", 8'h01, {7'h0, pe});
    rst(3'h5);
    wr(IRM_OFS_MODE, 8'h03);
    dec(16'h0010, 1'b0);
    chk("pd", 8'h01, {7'h0, pd});
    chk("pe", 8'h00, {7'h0, pe});
    rst(3'h6);
    chk("mode", 8'h02, {5'h0, mode});
    chk("pd", 8'h00, {7'h0, pd});
    summarize();
  end
endmodule : irm_mapper_tb_top
`default_nettype wire

// file: verilog/irm_mapper.sv
/*
  irm_mapper: address-map control for the internal bus. decodes each
  access to one resource, holds the position and mapping registers and
  the visibility / emulation controls.
  assumes mode straps are steady around reset release and that the
  register port master never raises read and write together.
*/
// Summary of operation
// [RULE1] visibility bit set drives internal accesses onto external bus
// [RULE2] special narrow, visibility and port d emulation: wide data on c/d
// [RULE3] no visibility at all in single-chip modes
// [RULE4] mode control bits: once in normal, first write lost in special
// [RULE5] wide and peripheral modes drop the four port d registers
// [RULE6] single-chip and normal narrow keep the port d registers
// [RULE7] special narrow: port d emulation bit removes port d registers
// [RULE8] expanded modes: port e emulation bit removes port e registers
// [RULE9] single-chip keeps port e registers regardless
// [RULE10] position writes act from the cycle after the write
// [RULE11] priority: debug rom, registers, ram, eeprom, external
// [RULE12] unclaimed addresses go to external memory
// [RULE13] 512-byte register block at zero, movable on 2k boundaries
// [RULE14] register position bits give address 15..11, write once normal
// [RULE15] 1k ram sits in the upper half of its 2k block
// [RULE16] ram position bits give address 15..11, reset base 0x0800
// [RULE17] eeprom on 4k boundaries, reset 0001 expanded, 1111 single-chip
// [RULE18] eeprom enable forced on in single-chip, else writable anytime
// [RULE19] extra window at 0x0400 or 0x0000 when enabled in expanded modes
// [RULE20] narrow bit makes register-following cs space an 8-bit access
// [RULE21] misc register once in normal, anytime in special
// [RULE22] expansion window only in expanded modes
// [RULE23] mode flag and mode bits caught from pins at reset release
// [RULE24] unimplemented bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module irm_mapper (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_bkgd_pin,
  input wire logic i_modb_pin,
  input wire logic i_moda_pin,
  input wire irm_pkg::irm_acc_t i_acc,
  input wire logic i_extra_window_enable,
  input wire logic i_low_cs_enabled,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output irm_pkg::irm_sel_t o_sel,
  output irm_pkg::irm_vis_t o_vis,
  output logic o_port_d_mapped,
  output logic o_port_e_mapped,
  output logic o_extra_page_window_hit,
  output logic o_cs_narrow,
  output logic [2:0] o_mode,
  output logic o_mode_ready
);
  import irm_pkg::*;

  function automatic logic is_single(input logic [2:0] m);
    is_single = (m[1:0] == 2'b00);
  endfunction : is_single

  function automatic logic is_expanded(input logic [2:0] m);
    is_expanded = m[0];
  endfunction : is_expanded

  function automatic logic is_wide_or_per(input logic [2:0] m);
    is_wide_or_per = m[1];
  endfunction : is_wide_or_per

  // strap synchronisers: only stage 3 and the stage-2/3 compare are used
  logic [2:0] bkgd_s_r;
  logic [2:0] modb_s_r;
  logic [2:0] moda_s_r;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      bkgd_s_r <= 3'h0;
      modb_s_r <= 3'h0;
      moda_s_r <= 3'h0;
    end else begin
      bkgd_s_r <= {bkgd_s_r[1:0], i_bkgd_pin};
      modb_s_r <= {modb_s_r[1:0], i_modb_pin};
      moda_s_r <= {moda_s_r[1:0], i_moda_pin};
    end
  end

  logic straps_stable;
  assign straps_stable = (bkgd_s_r[1] == bkgd_s_r[2]) &&
                         (modb_s_r[1] == modb_s_r[2]) &&
                         (moda_s_r[1] == moda_s_r[2]);

  irm_state_t state_r;
  logic [1:0] fill_r;
  logic capture;
  assign capture = (state_r == IRM_ST_SYNC) && (fill_r == IRM_SYNC_CYCLES)
                   && straps_stable;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= IRM_ST_SYNC;
      fill_r <= 2'h0;
    end else begin
      case (state_r)
        IRM_ST_SYNC: begin
          if (fill_r != IRM_SYNC_CYCLES) begin
            fill_r <= fill_r + 2'h1;
          end
          if (capture) begin
            state_r <= IRM_ST_RUN;
          end
        end
        IRM_ST_RUN: state_r <= IRM_ST_RUN;
        default: state_r <= IRM_ST_SYNC;
      endcase
    end
  end

  // reserved strap code is forced to special peripheral
  logic [2:0] strap_mode;
  always_comb begin
    strap_mode = {bkgd_s_r[2], modb_s_r[2], moda_s_r[2]};
    if (strap_mode == IRM_M_RESERVED) begin
      strap_mode = IRM_M_SP_PER;
    end
  end

  logic [2:0] mode_r;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_r <= IRM_M_SP_SC;
    end else if (capture) begin
      mode_r <= strap_mode; // RULE23
    end
  end

  logic special;
  logic run;
  assign special = !mode_r[2];
  assign run = (state_r == IRM_ST_RUN);

  logic wr_mode, wr_ram, wr_reg, wr_ee, wr_misc;
  assign wr_mode = run && i_reg_wr && (i_reg_addr == IRM_OFS_MODE);
  assign wr_ram = run && i_reg_wr && (i_reg_addr == IRM_OFS_RAM_POS);
  assign wr_reg = run && i_reg_wr && (i_reg_addr == IRM_OFS_REG_POS);
  assign wr_ee = run && i_reg_wr && (i_reg_addr == IRM_OFS_EE_POS);
  assign wr_misc = run && i_reg_wr && (i_reg_addr == IRM_OFS_MISC);

  // write history: once-only in normal, and the mode register's first-write skip in special
  logic seen_mode_r, seen_ram_r, seen_reg_r, seen_ee_r, seen_misc_r;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      seen_mode_r <= 1'b0;
      seen_ram_r <= 1'b0;
      seen_reg_r <= 1'b0;
      seen_ee_r <= 1'b0;
      seen_misc_r <= 1'b0;
    end else begin
      if (wr_mode) seen_mode_r <= 1'b1;
      if (wr_ram) seen_ram_r <= 1'b1;
      if (wr_reg) seen_reg_r <= 1'b1;
      if (wr_ee) seen_ee_r <= 1'b1;
      if (wr_misc) seen_misc_r <= 1'b1;
    end
  end

  // in both mode kinds a first write is the one that matters:
  // normal takes only it, special drops only it
  logic mode_ok;
  assign mode_ok = wr_mode && (special ? seen_mode_r : !seen_mode_r); // RULE4

  logic internal_visibility_bit_r, emd_r, eme_r;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      internal_visibility_bit_r <= 1'b0;
      emd_r <= 1'b0;
      eme_r <= 1'b0;
    end else if (capture) begin
      internal_visibility_bit_r <= !strap_mode[2];
      emd_r <= !strap_mode[2];
      eme_r <= !strap_mode[2];
    end else if (mode_ok) begin
      internal_visibility_bit_r <= i_reg_wdata[IRM_MODE_INTERNAL_VISIBILITY_BIT]; // RULE4
      emd_r <= i_reg_wdata[IRM_MODE_EMD];
      eme_r <= i_reg_wdata[IRM_MODE_EME];
    end
  end

  logic [4:0] reg_pos_r;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      reg_pos_r <= IRM_RST_REG_POS; // RULE13
    end else if (wr_reg && (special || !seen_reg_r)) begin
      reg_pos_r <= i_reg_wdata[7:3]; // RULE14
    end
  end

  logic [4:0] ram_pos_r;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ram_pos_r <= IRM_RST_RAM_POS;
    end else if (wr_ram && (special || !seen_ram_r)) begin
      ram_pos_r <= i_reg_wdata[7:3]; // RULE16
    end
  end

  logic [3:0] ee_pos_r;
  logic eeprom_map_enable_r;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ee_pos_r <= IRM_RST_EE_EXP;
      eeprom_map_enable_r <= 1'b1;
    end else if (capture) begin
      ee_pos_r <= is_single(strap_mode) ? IRM_RST_EE_SC :
                  IRM_RST_EE_EXP; // RULE17
      eeprom_map_enable_r <= 1'b1;
    end else if (wr_ee) begin
      if (special || !seen_ee_r) begin
        ee_pos_r <= i_reg_wdata[7:4]; // RULE17
      end
      eeprom_map_enable_r <= is_single(mode_r) | i_reg_wdata[IRM_EE_EEPROM_MAP_ENABLE]; // RULE18
    end
  end

  logic [1:0] misc_r;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      misc_r <= IRM_RST_MISC;
    end else if (wr_misc && (special || !seen_misc_r)) begin
      misc_r <= i_reg_wdata[7:6]; // RULE21
    end
  end

  // read data in the cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        IRM_OFS_MODE:
          o_reg_rdata <= {mode_r, 1'b0, internal_visibility_bit_r, 1'b0, emd_r, eme_r};
        IRM_OFS_RAM_POS: o_reg_rdata <= {ram_pos_r, 3'h0}; // RULE24
        IRM_OFS_REG_POS: o_reg_rdata <= {reg_pos_r, 3'h0};
        IRM_OFS_EE_POS: o_reg_rdata <= {ee_pos_r, 3'h0, eeprom_map_enable_r};
        IRM_OFS_MISC: o_reg_rdata <= {misc_r, 6'h00};
        default: o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // decode, using the positions as they stand before any same-cycle write
  logic [15:0] a;
  logic [8:0] ofs;
  assign a = i_acc.addr;
  assign ofs = a[8:0];

  logic is_port_d, is_port_e, port_d_map, port_e_map;
  assign is_port_d = (ofs == IRM_OFS_PORT_D_DATA_REG_DATA) ||
                     (ofs == IRM_OFS_PORT_D_DATA_REG_DIR) ||
                     (ofs == IRM_OFS_PORT_D_DATA_REG_WKEN) ||
                     (ofs == IRM_OFS_PORT_D_DATA_REG_WKFL);
  assign is_port_e = (ofs == IRM_OFS_PORT_E_DATA_REG_DATA) ||
                     (ofs == IRM_OFS_PORT_E_DATA_REG_DIR);

  always_comb begin
    if (is_wide_or_per(mode_r)) begin
      port_d_map = 1'b0; // RULE5
    end else if (mode_r == IRM_M_SP_NAR) begin
      port_d_map = !emd_r; // RULE7
    end else begin
      port_d_map = 1'b1; // RULE6
    end
    if (is_expanded(mode_r)) begin
      port_e_map = !eme_r; // RULE8
    end else begin
      port_e_map = 1'b1; // RULE9
    end
  end

  logic hit_bdm, hit_reg, hit_ram, hit_ee, hit_cs_space;
  assign hit_bdm = i_acc.bdm_active && (a[15:8] == IRM_BDM_PAGE);
  assign hit_reg = (a[15:11] == reg_pos_r) && (a[10:9] == 2'b00) &&
                   !(is_port_d && !port_d_map) &&
                   !(is_port_e && !port_e_map); // RULE13
  assign hit_ram = (a[15:11] == ram_pos_r) && a[10]; // RULE15
  assign hit_ee = eeprom_map_enable_r && (a[15:12] == ee_pos_r); // RULE18
  assign hit_cs_space = (a[15:11] == reg_pos_r) && (a[10:9] == 2'b01);

  irm_sel_t sel_nxt;
  always_comb begin
    sel_nxt = '0;
    if (i_acc.valid) begin
      if (hit_bdm) begin
        sel_nxt.bdm_rom = 1'b1; // RULE11
      end else if (hit_reg) begin
        sel_nxt.regs = 1'b1;
      end else if (hit_ram) begin
        sel_nxt.ram = 1'b1;
      end else if (hit_ee) begin
        sel_nxt.eeprom = 1'b1;
      end else begin
        sel_nxt.external = 1'b1; // RULE12
      end
    end
  end

  logic internal_nxt;
  assign internal_nxt = i_acc.valid && !sel_nxt.external;

  // window index into the low 2k: 0x0400 page when placement is 0
  logic [5:0] extra_page_window_base;
  assign extra_page_window_base = misc_r[1] ? IRM_EXTRA_PAGE_WINDOW_LOW : IRM_EXTRA_PAGE_WINDOW_HIGH;

  // registered decode: a mapping write changes the answer from the
  // access one cycle after it, so a following no-op covers the gap
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sel <= '0;
    end else begin
      o_sel <= sel_nxt; // RULE10
    end
  end

  // visibility belongs to the same access as the select beside it
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_vis <= '0;
    end else begin
      o_vis.drive <= internal_nxt && internal_visibility_bit_r &&
                     !is_single(mode_r); // RULE1 RULE3
      o_vis.wide <= internal_nxt && internal_visibility_bit_r && emd_r &&
                    (mode_r == IRM_M_SP_NAR); // RULE2
    end
  end

  // internal resources win over the window, so only external hits count
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_extra_page_window_hit <= 1'b0;
    end else begin
      o_extra_page_window_hit <= sel_nxt.external && is_expanded(mode_r) &&
                     i_extra_window_enable &&
                     (a[15:10] == extra_page_window_base); // RULE19 RULE22
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cs_narrow <= 1'b0;
    end else begin
      o_cs_narrow <= sel_nxt.external && hit_cs_space &&
                     misc_r[0] && i_low_cs_enabled &&
                     is_expanded(mode_r) && mode_r[1]; // RULE20
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_port_d_mapped <= 1'b1;
      o_port_e_mapped <= 1'b1;
    end else begin
      o_port_d_mapped <= port_d_map;
      o_port_e_mapped <= port_e_map;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mode <= IRM_M_SP_SC;
      o_mode_ready <= 1'b0;
    end else begin
      o_mode <= mode_r;
      o_mode_ready <= run;
    end
  end
endmodule : irm_mapper
`default_nettype wire

// file: verilog/irm_pkg.sv
/*
  irm_pkg: constants and carrier types for the internal resource mapper.
  assumes a 10 MHz bus clock and 8-bit register offsets in the
  register block.
*/
`default_nettype none
package irm_pkg;
  // register offsets inside the register block
  localparam logic [7:0] IRM_OFS_MODE = 8'h0b;
  localparam logic [7:0] IRM_OFS_RAM_POS = 8'h10;
  localparam logic [7:0] IRM_OFS_REG_POS = 8'h11;
  localparam logic [7:0] IRM_OFS_EE_POS = 8'h12;
  localparam logic [7:0] IRM_OFS_MISC = 8'h13;
  // port d / port e register offsets that emulation removes
  localparam logic [8:0] IRM_OFS_PORT_D_DATA_REG_DATA = 9'h005;
  localparam logic [8:0] IRM_OFS_PORT_D_DATA_REG_DIR = 9'h007;
  localparam logic [8:0] IRM_OFS_PORT_D_DATA_REG_WKEN = 9'h020;
  localparam logic [8:0] IRM_OFS_PORT_D_DATA_REG_WKFL = 9'h021;
  localparam logic [8:0] IRM_OFS_PORT_E_DATA_REG_DATA = 9'h008;
  localparam logic [8:0] IRM_OFS_PORT_E_DATA_REG_DIR = 9'h009;
  // field positions
  localparam int IRM_MODE_SPECIAL_MODE_NOT_FLAG = 7;
  localparam int IRM_MODE_INTERNAL_VISIBILITY_BIT = 3;
  localparam int IRM_MODE_EMD = 1;
  localparam int IRM_MODE_EME = 0;
  localparam int IRM_EE_EEPROM_MAP_ENABLE = 0;
  localparam int IRM_MISC_EXTRA_WINDOW_PLACEMENT = 7;
  localparam int IRM_MISC_NARROW_REGISTER_SPACE_BUS = 6;
  // reset values
  localparam logic [4:0] IRM_RST_REG_POS = 5'h00;
  localparam logic [4:0] IRM_RST_RAM_POS = 5'h01;
  localparam logic [3:0] IRM_RST_EE_EXP = 4'h1;
  localparam logic [3:0] IRM_RST_EE_SC = 4'hf;
  localparam logic [1:0] IRM_RST_MISC = 2'h0;
  // address windows
  localparam logic [7:0] IRM_BDM_PAGE = 8'hff;
  localparam logic [5:0] IRM_EXTRA_PAGE_WINDOW_LOW = 6'h00;
  localparam logic [5:0] IRM_EXTRA_PAGE_WINDOW_HIGH = 6'h01;
  // strap synchroniser fill time
  localparam logic [1:0] IRM_SYNC_CYCLES = 2'h3;
  // mode codes {special_mode_not_flag, modb, moda}
  localparam logic [2:0] IRM_M_SP_SC = 3'h0;
  localparam logic [2:0] IRM_M_SP_NAR = 3'h1;
  localparam logic [2:0] IRM_M_SP_PER = 3'h2;
  localparam logic [2:0] IRM_M_SP_WIDE = 3'h3;
  localparam logic [2:0] IRM_M_RESERVED = 3'h6;

  typedef enum logic [1:0] {
    IRM_ST_SYNC = 2'b01,
    IRM_ST_RUN = 2'b10
  } irm_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic bdm_active;
    logic [15:0] addr;
  } irm_acc_t;

  typedef struct packed {
    logic bdm_rom;
    logic regs;
    logic ram;
    logic eeprom;
    logic external;
  } irm_sel_t;

  typedef struct packed {
    logic drive;
    logic wide;
  } irm_vis_t;
endpackage : irm_pkg
`default_nettype wire
